// file: rtl/acq_trigger.sv
`timescale 1ns/1ps
`default_nettype none
module acq_fifo #(
  parameter int W = 16,
  parameter int D = 16
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int AWF = $clog2(D);
  logic [W-1:0]   mem_q [D];
  logic [AWF:0]   wp_q, wp_d, rp_q, rp_d;
  logic           push, pop;
  // pointer arithmetic
  always_comb begin
    in_ready_o  = (wp_q - rp_q) != (AWF+1)'(D);
    out_valid_o = wp_q != rp_q;
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    wp_d        = push ? wp_q + 1'b1 : wp_q;
    rp_d        = pop ? rp_q + 1'b1 : rp_q;
    out_data_o  = mem_q[rp_q[AWF-1:0]];
  end
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
    if (push) mem_q[wp_q[AWF-1:0]] <= in_data_i;
  end
endmodule // acq_fifo

module acq_trigger
  import acq_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  // host configuration
  input  wire cfg_s              cfg_i,
  input  wire logic              cfg_load_i,
  input  wire logic              start_i,
  // sample sources, pins
  input  wire logic              int_tick_i,
  input  wire logic              probe_clk_i,
  input  wire logic [CHAN-1:0]   probe_data_i,
  // expanders, pins
  input  wire logic [2:0]        exp_match_i,
  input  wire logic [3*CHAN-1:0] exp_data_i,
  output logic                   exp_clk_en_o,
  // slow card arm, pin
  input  wire logic              slow_done_i,
  // readback and status
  input  wire logic              rd_req_i,
  input  wire logic [AW-1:0]     rd_addr_i,
  output logic [CHAN-1:0]        rd_data_o,
  output logic                   stop_store_o,
  output logic                   acq_done_o,
  output logic                   match_o,
  // captured stream
  output logic                   smp_valid_o,
  input  wire logic              smp_ready_i,
  output logic [FIFO_W-1:0]      smp_data_o
);
  // pin synchronisers
  logic [1:0] tick_s1_q, tick_s2_q, pclk_s1_q, pclk_s2_q, slow_s1_q, slow_s2_q;
  logic [CHAN-1:0]   pd_s1_q, pd_s2_q;
  logic [3*CHAN-1:0] ed_s1_q, ed_s2_q;
  logic [2:0]        em_s1_q, em_s2_q;
  logic              pclk_prev_q, tick_prev_q;
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      {tick_s1_q, tick_s2_q, pclk_s1_q, pclk_s2_q, slow_s1_q, slow_s2_q} <= '0;
      {pd_s1_q, pd_s2_q, ed_s1_q, ed_s2_q, em_s1_q, em_s2_q} <= '0;
      pclk_prev_q <= 1'b0;
      tick_prev_q <= 1'b0;
    end else begin
      tick_s1_q   <= {1'b0, int_tick_i};
      tick_s2_q   <= tick_s1_q;
      pclk_s1_q   <= {1'b0, probe_clk_i};
      pclk_s2_q   <= pclk_s1_q;
      slow_s1_q   <= {1'b0, slow_done_i};
      slow_s2_q   <= slow_s1_q;
      pd_s1_q     <= probe_data_i;
      pd_s2_q     <= pd_s1_q;
      ed_s1_q     <= exp_data_i;
      ed_s2_q     <= ed_s1_q;
      em_s1_q     <= exp_match_i;
      em_s2_q     <= em_s1_q;
      pclk_prev_q <= pclk_s2_q[0];
      tick_prev_q <= tick_s2_q[0];
    end
  end

  cfg_s            cfg_q, cfg_d;
  state_e          st_q, st_d;
  logic [DLY_W-1:0] cnt_q, cnt_d;
  logic [AW-1:0]   wa_q, wa_d;
  logic            clk_en_q, clk_en_d, stop_q, stop_d, done_q, done_d;
  logic            match_q, match_d;
  logic [CHAN-1:0] mem_q [DEPTH];
  logic [CHAN-1:0] rd_q;
  logic            edge_hit, all_match, mat_en, fifo_rdy;
  logic [2:0]      exp_ok;
  logic [CHAN-1:0] nib [NMOD];
  logic              f_valid, f_pop, sv_q, sv_d;
  logic [FIFO_W-1:0] f_data, sd_q, sd_d;

  function automatic logic pick_edge(input logic cur, input logic prev, input logic fall);
    pick_edge = fall ? (prev && !cur) : (!prev && cur);
  endfunction

  // sample edge select; stalls if stream buffer full
  always_comb begin
    edge_hit = clk_en_q && fifo_rdy && (cfg_q.clk_src
               ? pick_edge(pclk_s2_q[0], pclk_prev_q, cfg_q.edge_fall)
               : pick_edge(tick_s2_q[0], tick_prev_q, 1'b0));
    nib[0] = pd_s2_q;
    for (int i = 0; i < 3; i++) begin
      nib[i+1] = ed_s2_q[i*CHAN +: CHAN];
      // uninstalled slots forced true
      exp_ok[i] = (2'(i) >= cfg_q.n_exp) || em_s2_q[i];
    end
    mat_en    = (st_q == S_RUN);
    all_match = mat_en && (nib[0] == cfg_q.match_word[CHAN-1:0]) && (&exp_ok);
  end

  // control sequence
  always_comb begin
    st_d     = st_q;
    cfg_d    = cfg_q;
    cnt_d    = cnt_q;
    wa_d     = wa_q;
    clk_en_d = clk_en_q;
    stop_d   = 1'b0;
    done_d   = done_q;
    match_d  = all_match;
    if (edge_hit) wa_d = wa_q + 1'b1;
    unique case (st_q)
      S_IDLE: begin
        if (cfg_load_i) cfg_d = cfg_i;
        if (start_i) begin
          clk_en_d = 1'b1;
          done_d   = 1'b0;
          wa_d     = '0;
          st_d     = cfg_q.arm_slow ? S_WAIT_ARM : S_RUN;
        end
      end
      S_WAIT_ARM: if (slow_s2_q[0]) st_d = S_RUN;
      S_RUN: if (edge_hit && all_match) begin
        cnt_d = ~cfg_q.delay;
        st_d  = S_DELAY;
      end
      S_DELAY: if (edge_hit) begin
        if (cnt_q == DLY_ONES) begin
          stop_d   = 1'b1;
          clk_en_d = 1'b0;
          st_d     = S_DONE;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      S_DONE: begin
        done_d = 1'b1;
        st_d   = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_q     <= S_IDLE;
      cfg_q    <= '0;
      cnt_q    <= '0;
      wa_q     <= '0;
      clk_en_q <= 1'b0;
      stop_q   <= 1'b0;
      done_q   <= 1'b0;
      match_q  <= 1'b0;
    end else begin
      st_q     <= st_d;
      cfg_q    <= cfg_d;
      cnt_q    <= cnt_d;
      wa_q     <= wa_d;
      clk_en_q <= clk_en_d;
      stop_q   <= stop_d;
      done_q   <= done_d;
      match_q  <= match_d;
    end
  end

  // master store; expanders hold their own
  always_ff @(posedge ref_clk_i) begin
    if (edge_hit) mem_q[wa_q] <= nib[0];
    if (!rst_n_i) rd_q <= '0;
    else if (rd_req_i) rd_q <= mem_q[rd_addr_i];
  end

  acq_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (edge_hit),
    .in_ready_o  (fifo_rdy),
    .in_data_i   ({nib[3], nib[2], nib[1], nib[0]}),
    .out_valid_o (f_valid),
    .out_ready_i (f_pop),
    .out_data_o  (f_data)
  );

  // output slice so the stream pins come from flops; adds one word of depth
  always_comb begin
    f_pop = !sv_q || smp_ready_i;
    sv_d  = sv_q;
    sd_d  = sd_q;
    if (f_pop) begin
      sv_d = f_valid;
      sd_d = f_data;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      sv_q <= 1'b0;
      sd_q <= '0;
    end else begin
      sv_q <= sv_d;
      sd_q <= sd_d;
    end
  end

  assign smp_valid_o  = sv_q;
  assign smp_data_o   = sd_q;
  assign exp_clk_en_o = clk_en_q;
  assign stop_store_o = stop_q;
  assign acq_done_o   = done_q;
  assign match_o      = match_q;
  assign rd_data_o    = rd_q;
endmodule // acq_trigger
`default_nettype wire

// file: rtl/acq_pkg.sv
// Function
// - four channels per module, 2048-word store
// - zero to three expanders, sixteen channels
// - host loads source, edge, word, delay
// - master starts clock, drives it to expanders
// - every module captures one word per edge
// - expanders sample at master clock rate
// - compare captured nibble to slice, flag match
// - expander matches combined with master match
// - trigger only when all modules match together
// - delay counter runs, then stop-store request
// - delay end gates clock to all modules
// - report acquisition complete after clock stops
// - slow-card arm disables word matchers
// - slow-card trigger done enables master matcher
// - delay loaded ones' complement, counts to ones
package acq_pkg;
  localparam int NMOD      = 4;
  localparam int CHAN      = 4;
  localparam int DEPTH     = 2048;
  localparam int AW        = 11;
  localparam int DLY_W     = 15;
  localparam int FIFO_W    = NMOD*CHAN;
  localparam int FIFO_D    = 16;
  localparam logic [DLY_W-1:0] DLY_ONES = 15'h7FFF;

  typedef struct packed {
    logic             clk_src;   // 0 internal tick, 1 probe clock
    logic             edge_fall; // active edge select for probe clock; internal tick always rising
    logic [15:0]      match_word;
    logic [DLY_W-1:0] delay;
    logic [1:0]       n_exp;
    logic             arm_slow;
  } cfg_s;

  typedef enum logic [2:0] {S_IDLE, S_WAIT_ARM, S_RUN, S_DELAY, S_DONE} state_e;
endpackage

// file: verification/acq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module acq_asserts
  import acq_pkg::*;
(
  // watched ports
  input wire logic              ref_clk_i, rst_n_i, start_i, smp_ready_i,
  input wire logic              exp_clk_en_o, stop_store_o, acq_done_o, smp_valid_o, match_o,
  input wire logic [FIFO_W-1:0] smp_data_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_stop_gates_clk: assert property (stop_store_o |=> !exp_clk_en_o)
    else $error("sample clock still on after stop");
  a_stop_then_done: assert property (stop_store_o |=> acq_done_o)
    else $error("done missing after stop");
  a_done_cause: assert property ($rose(acq_done_o) |-> $past(stop_store_o))
    else $error("done without stop");
  a_stop_one_pulse: assert property (stop_store_o |=> !stop_store_o)
    else $error("stop pulse too long");
  a_stop_in_run: assert property (stop_store_o |-> $past(exp_clk_en_o))
    else $error("stop outside a run");
  a_match_in_run: assert property (match_o |-> exp_clk_en_o)
    else $error("match flagged outside a run");
  a_start_clock: assert property (start_i && !exp_clk_en_o |=> exp_clk_en_o && !acq_done_o)
    else $error("start did not launch clock");
  a_done_no_clock: assert property (acq_done_o |-> !exp_clk_en_o)
    else $error("clock on while done");
  a_stream_hold: assert property (smp_valid_o && !smp_ready_i |=> smp_valid_o && $stable(smp_data_o))
    else $error("stream word lost under stall");
endmodule // acq_asserts
`default_nettype wire

// file: verification/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
  import acq_pkg::*;
(
  input wire logic        ref_clk_i,
  output cfg_s            cfg_o,
  output logic            load_o, start_o, rd_o,
  output logic [AW-1:0]   addr_o
);
  initial {cfg_o, load_o, start_o, rd_o, addr_o} = '0;
  // settings go in while idle, start follows as a single pulse
  task automatic run(input cfg_s c);
    @(posedge ref_clk_i) #1 cfg_o = c;
    load_o = 1;
    @(posedge ref_clk_i) #1 load_o = 0;
    start_o = 1;
    @(posedge ref_clk_i) #1 start_o = 0;
  endtask
  // readback only after done; address inverted once released
  task automatic read(input logic [AW-1:0] a);
    @(posedge ref_clk_i) #1 rd_o = 1;
    addr_o = a;
    @(posedge ref_clk_i) #1 rd_o = 0;
    addr_o = ~a;
  endtask
endmodule // host_model
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import acq_pkg::*;
;
  logic ref_clk_i = 0, rst_n_i = 0, int_tick_i = 0, slow_done_i = 0, smp_ready_i = 1, tick_en = 0;
  logic cfg_load_i, start_i, rd_req_i, exp_clk_en_o, stop_store_o, acq_done_o, match_o, smp_valid_o;
  logic [3:0] probe_data_i = 0, rd_data_o;
  logic [2:0] exp_match_i = 0;
  logic [AW-1:0] rd_addr_i;
  logic [15:0] smp_data_o, lastw;
  cfg_s cfg_i;
  int num_errors = 0, n_compared = 0, cyc = 0, nw = 0;
  host_model host (.ref_clk_i, .cfg_o(cfg_i), .load_o(cfg_load_i), .start_o(start_i), .rd_o(rd_req_i),
    .addr_o(rd_addr_i));
  acq_trigger dut (.ref_clk_i, .rst_n_i, .cfg_i, .cfg_load_i, .start_i, .int_tick_i, .probe_clk_i(1'b0),
    .probe_data_i, .exp_match_i, .exp_data_i(12'hABC), .exp_clk_en_o, .slow_done_i, .rd_req_i, .rd_addr_i,
    .rd_data_o, .stop_store_o, .acq_done_o, .match_o, .smp_valid_o, .smp_ready_i, .smp_data_o);
  initial forever #4 ref_clk_i = ~ref_clk_i;
  // slow tick, data ramps on its falling side so it is settled when taken
  always @(posedge ref_clk_i) begin
    #1 cyc++;
    if (tick_en && cyc % 4 == 0) begin
      if (int_tick_i) probe_data_i++;
      int_tick_i = ~int_tick_i;
    end
    if (cyc == 30000) begin
      num_errors++;
      stop_test();
    end
  end
  // handshake seen mid-cycle, clear of the edge updates
  always @(negedge ref_clk_i) if (smp_valid_o === 1 && smp_ready_i) begin
    lastw = smp_data_o;
    nw++;
  end
  task automatic check(input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wait_done();
    repeat (3000) if (acq_done_o !== 1) @(posedge ref_clk_i);
    repeat (8) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic s_master();
    exp_match_i = 0; // absent slots must not block
    nw = 0;
    host.run('{0, 0, 16'h0005, 15'h2, 2'h0, 0});
    wait_done();
    check(acq_done_o, 1);
    check(lastw, 16'hABC8);
    host.read(11'(nw - 1));
    check(rd_data_o, 16'h0008);
  endtask
  task automatic s_exp();
    exp_match_i = 3'b011;
    host.run('{0, 0, 16'h0005, 15'h0, 2'h3, 0});
    repeat (400) @(posedge ref_clk_i);
    #1;
    check(acq_done_o, 0);
    exp_match_i = 3'b111;
    wait_done();
    check(acq_done_o, 1);
  endtask
  task automatic s_slow();
    exp_match_i = 0;
    host.run('{0, 0, 16'h0005, 15'h0, 2'h0, 1});
    repeat (400) @(posedge ref_clk_i);
    #1;
    check(acq_done_o, 0);
    smp_ready_i = 0;
    repeat (300) @(posedge ref_clk_i);
    #1 tick_en = 0;
    // let any tick edge in flight die against the full buffer
    repeat (16) @(posedge ref_clk_i);
    #1 nw = 0;
    smp_ready_i = 1;
    repeat (40) @(posedge ref_clk_i);
    #1;
    check(nw, FIFO_D + 1);
    #1 slow_done_i = 1;
    tick_en = 1;
    wait_done();
    check(acq_done_o, 1);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_i);
    #1 rst_n_i = 1;
    tick_en = 1;
    s_master();
    s_exp();
    s_slow();
    stop_test();
  end
endmodule // tb_top
bind acq_trigger acq_asserts chk (.ref_clk_i, .rst_n_i, .start_i, .smp_ready_i, .exp_clk_en_o, .stop_store_o,
  .acq_done_o, .smp_valid_o, .match_o, .smp_data_o);
`default_nettype wire
